// File: design/sfts_defs.svh
`ifndef SFTS_DEFS_SVH
`define SFTS_DEFS_SVH

// Memory geometry
`define SFTS_ADDR_W 14
`define SFTS_MEM_DEPTH 16384
// Slave address layout
`define SFTS_TYPE_ID 4'ha
`define SFTS_TYPE_MSB 7
`define SFTS_TYPE_LSB 4
`define SFTS_SEL_MSB 3
`define SFTS_SEL_LSB 1
`define SFTS_RW_BIT 0
// High-speed master code: top five bits fixed, low three free
`define SFTS_HS_PREFIX 5'h01
`define SFTS_MASTER_CODE 8'h08
// Clocking
`define SFTS_CLK_HZ 10000000
`define SFTS_SCL_HZ 500000
`define SFTS_QUARTER_CYC (`SFTS_CLK_HZ / (4 * `SFTS_SCL_HZ))
`define SFTS_FILT_CYC 2

`endif

// File: design/sfts_pkg.sv
package sfts_pkg;

    // Slave end states
    typedef enum logic [2:0] {
        D_IDLE = 3'b000,
        D_RX = 3'b001,
        D_ACK = 3'b010,
        D_TX = 3'b011,
        D_TXACK = 3'b100
    } sfts_dst_t;

    // Master end states
    typedef enum logic [1:0] {
        M_IDLE = 2'b00,
        M_START = 2'b01,
        M_BIT = 2'b10,
        M_STOP = 2'b11
    } sfts_mst_t;

    // Master transfer kinds
    typedef enum logic [1:0] {
        OP_WRITE = 2'b00,
        OP_SETADDR = 2'b01,
        OP_READ = 2'b10
    } sfts_op_t;

    // Whole slave state
    typedef struct packed {
        logic [1:0] scl_sync;
        logic [1:0] sda_sync;
        logic [2:0] scl_cnt;
        logic [2:0] sda_cnt;
        logic scl_f;
        logic sda_f;
        sfts_dst_t st;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic [1:0] phase;
        logic rw;
        logic ack_ok;
        logic [5:0] addr_hi;
        logic [13:0] addr;
        logic hs;
        logic sda_oe;
        logic busy;
        logic [2:0] sel_s1;
        logic [2:0] sel_s2;
        logic [1:0] wp_sync;
    } sfts_dev_t;

    // Whole master state
    typedef struct packed {
        logic [1:0] sda_sync;
        sfts_mst_t st;
        logic [7:0] q;
        logic [1:0] ph;
        logic [3:0] bitn;
        logic [1:0] bidx;
        sfts_op_t op;
        logic hs_pend;
        logic [2:0] sel;
        logic [13:0] addr;
        logic [7:0] wdata;
        logic [7:0] shreg;
        logic [7:0] rdata;
        logic scl;
        logic sda_oe;
        logic busy;
        logic done;
        logic nack;
    } sfts_mst_state_t;

endpackage

// File: design/sfts_bus_if.sv
`timescale 1ns/1ns
`default_nettype none

interface sfts_bus_if;
    logic scl; // Clock, driven by master only
    logic m_sda_out; // Master data driver value
    logic m_sda_oe; // Master pulls data low when high
    logic d_sda_out; // Slave data driver value
    logic d_sda_oe; // Slave pulls data low when high
    logic sda; // Resolved open-drain level, pulled up

    // Wired-AND of both open-drain drivers
    assign sda = !((m_sda_oe && !m_sda_out) || (d_sda_oe && !d_sda_out));

    modport master (output scl, output m_sda_out, output m_sda_oe, input sda);
    modport device (input scl, output d_sda_out, output d_sda_oe, input sda);
endinterface

`default_nettype wire

// File: design/sfts_device.sv
// Functional notes
// - Address is 14 bits, top two ignored
// - Slave only, never drives the clock
// - STOP aborts any operation in progress
// - Master sends STOP only owning data
// - START anytime aborts, awaits slave address
// - Master sends START after supply dip
// - Master keeps data stable while clock high
// - Ninth slot acknowledges; released line aborts
// - Master withholds acknowledge on last read
// - Master code enters high-speed; STOP leaves
// - First byte type bits must be 1010
// - Select bits must match select pins
// - Address bit zero: 1 read, 0 write
// - Two address bytes latched as 14 bits
// - Address held; reads start there
// - Increment address just before acknowledge
// - Address wraps 3fff to 0; unlimited length
// - Read: drive 8 bits, sample acknowledge
// - Write: take 8 bits, drive acknowledge
// - Every byte shifted MSB first
// - Array write finishes within bus protocol
// - Write-protect: no acknowledge, no increment
`timescale 1ns/1ns
`default_nettype none
`include "sfts_defs.svh"

module sfts_device
    import sfts_pkg::*;
#(
    parameter int FILT_CYC = `SFTS_FILT_CYC, // Stable samples to accept a level
    parameter int DEPTH = `SFTS_MEM_DEPTH // Bytes in the array
) (
    input wire logic i_clock, // System clock, 10 MHz
    input wire logic i_rst_b, // Async reset, active low
    sfts_bus_if.device bus, // Two-wire link
    input wire logic [2:0] i_device_select_pins, // Strapped select levels
    input wire logic i_write_protect, // High protects every address
    output logic o_hs_mode, // High-speed mode active
    output logic o_busy // Engaged in a transfer
);

    sfts_dev_t s; // Registered state
    sfts_dev_t n; // Next state
    logic [7:0] mem [0:DEPTH-1]; // Storage array
    logic mem_we; // Array write strobe
    logic [7:0] mem_wd; // Array write data
    logic [7:0] mem_rd; // Byte at current address
    logic scl_rise; // Filtered clock rising
    logic scl_fall; // Filtered clock falling
    logic start_det; // START seen
    logic stop_det; // STOP seen

    // Deglitch: a new level must persist FILT_CYC samples before it counts
    function automatic logic [3:0] filt(input logic [2:0] cnt, input logic cur,
                                        input logic raw);
        logic [3:0] r;
        r = {3'h0, cur};
        if (raw != cur) begin
            if (cnt == 3'(FILT_CYC - 1)) begin
                r = {3'h0, raw};
            end else begin
                r = {cnt + 3'h1, cur};
            end
        end
        return r;
    endfunction

    // Wrapping address step; 14-bit sum rolls 3fff over to 0000
    function automatic logic [13:0] next_addr(input logic [13:0] a);
        return a + 14'h0001;
    endfunction

    assign mem_rd = mem[s.addr];

    // Next-state logic for the whole slave
    always_comb begin
        n = s;
        mem_we = 1'b0;
        mem_wd = s.shreg;
        // Two-flop synchronisers; only the second flop feeds the filters
        n.scl_sync = {s.scl_sync[0], bus.scl};
        n.sda_sync = {s.sda_sync[0], bus.sda};
        // Strap and protect pins are asynchronous too; two flops before use
        n.sel_s1 = i_device_select_pins;
        n.sel_s2 = s.sel_s1;
        n.wp_sync = {s.wp_sync[0], i_write_protect};
        {n.scl_cnt, n.scl_f} = filt(s.scl_cnt, s.scl_f, s.scl_sync[1]);
        {n.sda_cnt, n.sda_f} = filt(s.sda_cnt, s.sda_f, s.sda_sync[1]);
        // Events come only from the master's transitions
        scl_rise = !s.scl_f && n.scl_f;
        scl_fall = s.scl_f && !n.scl_f;
        start_det = s.scl_f && n.scl_f && s.sda_f && !n.sda_f;
        stop_det = s.scl_f && n.scl_f && !s.sda_f && n.sda_f;
        if (start_det) begin
            // Any START restarts slave-address reception
            n.st = D_RX;
            n.phase = 2'h0;
            n.bitcnt = 4'h0;
            n.sda_oe = 1'b0;
        end else if (stop_det) begin
            // STOP aborts and drops high-speed mode
            n.st = D_IDLE;
            n.hs = 1'b0;
            n.sda_oe = 1'b0;
        end else if (scl_rise) begin
            case (s.st)
                D_RX: begin
                    // Receive MSB first on the rising edge
                    if (s.bitcnt != 4'h8) begin
                        n.shreg = {s.shreg[6:0], n.sda_f};
                        n.bitcnt = s.bitcnt + 4'h1;
                    end
                end
                D_TXACK: begin
                    // Low in the ninth slot is an acknowledge
                    n.ack_ok = !n.sda_f;
                end
                default: begin
                    // Nothing sampled in other states
                end
            endcase
        end else if (scl_fall) begin
            case (s.st)
                D_RX: begin
                    if (s.bitcnt == 4'h8) begin
                        case (s.phase)
                            2'h0: begin
                                if (s.shreg[7:3] == `SFTS_HS_PREFIX) begin
                                    // Master code is never acknowledged
                                    n.hs = 1'b1;
                                    n.st = D_IDLE;
                                end else if (s.shreg[`SFTS_TYPE_MSB:`SFTS_TYPE_LSB]
                                             == `SFTS_TYPE_ID
                                             && s.shreg[`SFTS_SEL_MSB:`SFTS_SEL_LSB]
                                             == s.sel_s2) begin
                                    n.rw = s.shreg[`SFTS_RW_BIT];
                                    n.phase = 2'h1;
                                    n.st = D_ACK;
                                    n.sda_oe = 1'b1;
                                end else begin
                                    // Not ours: stay off the bus
                                    n.st = D_IDLE;
                                end
                            end
                            2'h1: begin
                                // High address byte, top two bits dropped
                                n.addr_hi = s.shreg[5:0];
                                n.phase = 2'h2;
                                n.st = D_ACK;
                                n.sda_oe = 1'b1;
                            end
                            2'h2: begin
                                // Address is only loaded on a full second byte
                                n.addr = {s.addr_hi, s.shreg};
                                n.phase = 2'h3;
                                n.st = D_ACK;
                                n.sda_oe = 1'b1;
                            end
                            default: begin
                                if (s.wp_sync[1]) begin
                                    // Refused: no ack, address untouched
                                    n.st = D_IDLE;
                                end else begin
                                    // Array written before the ack slot opens
                                    mem_we = 1'b1;
                                    n.addr = next_addr(s.addr);
                                    n.st = D_ACK;
                                    n.sda_oe = 1'b1;
                                end
                            end
                        endcase
                    end
                end
                D_ACK: begin
                    // End of our acknowledge slot
                    n.sda_oe = 1'b0;
                    if (s.rw) begin
                        // Read starts at the held current address
                        n.shreg = {mem_rd[6:0], 1'b0};
                        n.sda_oe = !mem_rd[7];
                        n.bitcnt = 4'h1;
                        n.st = D_TX;
                    end else begin
                        n.bitcnt = 4'h0;
                        n.st = D_RX;
                    end
                end
                D_TX: begin
                    if (s.bitcnt == 4'h8) begin
                        // Release for master ack, step address first
                        n.sda_oe = 1'b0;
                        n.addr = next_addr(s.addr);
                        n.st = D_TXACK;
                    end else begin
                        n.sda_oe = !s.shreg[7];
                        n.shreg = {s.shreg[6:0], 1'b0};
                        n.bitcnt = s.bitcnt + 4'h1;
                    end
                end
                D_TXACK: begin
                    if (s.ack_ok) begin
                        // Acknowledged: next byte, no length limit
                        n.shreg = {mem_rd[6:0], 1'b0};
                        n.sda_oe = !mem_rd[7];
                        n.bitcnt = 4'h1;
                        n.st = D_TX;
                    end else begin
                        // Released slot ends the read
                        n.st = D_IDLE;
                    end
                end
                default: begin
                    // Idle ignores bus activity
                end
            endcase
        end
        n.busy = (n.st != D_IDLE);
    end

    // State register; lines idle high out of reset
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s <= '0;
            s.scl_sync <= 2'h3;
            s.sda_sync <= 2'h3;
            s.scl_f <= 1'b1;
            s.sda_f <= 1'b1;
            s.st <= D_IDLE;
        end else begin
            s <= n;
        end
    end

    // Array has no reset, as a real memory
    always_ff @(posedge i_clock) begin
        if (mem_we) begin
            mem[s.addr] <= mem_wd;
        end
    end

    assign bus.d_sda_out = 1'b0; // Open drain: only ever pulls low
    assign bus.d_sda_oe = s.sda_oe;
    assign o_hs_mode = s.hs;
    assign o_busy = s.busy;

endmodule

`default_nettype wire

// File: design/sfts_master.sv
`timescale 1ns/1ns
`default_nettype none
`include "sfts_defs.svh"

module sfts_master
    import sfts_pkg::*;
#(
    parameter int QUARTER = `SFTS_QUARTER_CYC // Clock cycles per quarter bit
) (
    input wire logic i_clock, // System clock, 10 MHz
    input wire logic i_rst_b, // Async reset, active low
    sfts_bus_if.master bus, // Two-wire link
    input wire logic i_req, // Start a transfer, one-cycle pulse
    input wire sfts_op_t i_op, // Transfer kind
    input wire logic i_hs, // Prefix master code for high speed
    input wire logic [2:0] i_target_select, // Target select bits
    input wire logic [13:0] i_addr, // Memory address
    input wire logic [7:0] i_wdata, // Byte to write
    output logic o_busy, // Transfer running
    output logic o_done, // Transfer ended, one-cycle pulse
    output logic o_nack, // Target refused a byte
    output logic [7:0] o_rdata // Last byte read
);

    sfts_mst_state_t s; // Registered state
    sfts_mst_state_t n; // Next state
    logic tick; // Quarter boundary
    logic rx; // Current byte comes from the target

    // Byte to send in slot idx; MSB-first order handled by the shifter
    function automatic logic [7:0] byte_of(input sfts_mst_state_t m, input logic [1:0] idx);
        logic [7:0] b;
        b = 8'h00;
        case (idx)
            2'h0: b = m.hs_pend ? `SFTS_MASTER_CODE
                  : {`SFTS_TYPE_ID, m.sel, m.op == OP_READ};
            2'h1: b = {2'h0, m.addr[13:8]};
            2'h2: b = m.addr[7:0];
            default: b = m.wdata;
        endcase
        return b;
    endfunction

    assign rx = (s.op == OP_READ) && (s.bidx == 2'h1);
    assign tick = (s.q == 8'(QUARTER - 1));

    // Next-state logic: four quarters per bit, clock made by division
    always_comb begin
        n = s;
        n.done = 1'b0;
        n.sda_sync = {s.sda_sync[0], bus.sda};
        if (s.st == M_IDLE) begin
            if (i_req) begin
                // Always open with START, also after a supply dip
                n.st = M_START;
                n.op = i_op;
                n.hs_pend = i_hs;
                n.sel = i_target_select;
                n.addr = i_addr;
                n.wdata = i_wdata;
                n.busy = 1'b1;
                n.nack = 1'b0;
                n.q = 8'h00;
                n.ph = 2'h0;
                n.bidx = 2'h0;
            end
        end else if (!tick) begin
            n.q = s.q + 8'h01;
        end else begin
            n.q = 8'h00;
            n.ph = s.ph + 2'h1;
            case (s.st)
                M_START: begin
                    case (s.ph)
                        2'h0: n.scl = 1'b0;
                        2'h1: n.sda_oe = 1'b0;
                        2'h2: n.scl = 1'b1;
                        default: begin
                            // Data falls with clock high
                            n.sda_oe = 1'b1;
                            n.st = M_BIT;
                            n.bitn = 4'h0;
                            n.shreg = byte_of(s, s.bidx);
                        end
                    endcase
                end
                M_BIT: begin
                    case (s.ph)
                        2'h0: n.scl = 1'b0;
                        2'h1: begin
                            // Data only moves while clock is low
                            if (s.bitn == 4'h8 || rx) begin
                                n.sda_oe = 1'b0;
                            end else begin
                                n.sda_oe = !s.shreg[7];
                            end
                        end
                        2'h2: n.scl = 1'b1;
                        default: begin
                            if (s.bitn != 4'h8) begin
                                n.rdata = rx ? {s.rdata[6:0], s.sda_sync[1]} : s.rdata;
                                n.shreg = {s.shreg[6:0], 1'b0};
                                n.bitn = s.bitn + 4'h1;
                            end else if (s.hs_pend) begin
                                // Master code sent; repeated START follows
                                n.hs_pend = 1'b0;
                                n.st = M_START;
                            end else if (!rx && s.sda_sync[1]) begin
                                n.nack = 1'b1;
                                n.st = M_STOP;
                            end else if (rx || (s.op == OP_SETADDR && s.bidx == 2'h2)
                                         || s.bidx == 2'h3) begin
                                n.st = M_STOP;
                            end else begin
                                n.bidx = s.bidx + 2'h1;
                                n.bitn = 4'h0;
                                n.shreg = byte_of(s, s.bidx + 2'h1);
                            end
                        end
                    endcase
                end
                default: begin
                    // STOP: pull data low, raise clock, release data
                    case (s.ph)
                        2'h0: n.scl = 1'b0;
                        2'h1: n.sda_oe = 1'b1;
                        2'h2: n.scl = 1'b1;
                        default: begin
                            n.sda_oe = 1'b0;
                            n.st = M_IDLE;
                            n.busy = 1'b0;
                            n.done = 1'b1;
                        end
                    endcase
                end
            endcase
        end
    end

    // State register; bus released, clock high after reset
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s <= '0;
            s.sda_sync <= 2'h3;
            s.st <= M_IDLE;
            s.op <= OP_WRITE;
            s.scl <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign bus.scl = s.scl;
    assign bus.m_sda_out = 1'b0;
    assign bus.m_sda_oe = s.sda_oe;
    assign o_busy = s.busy;
    assign o_done = s.done;
    assign o_nack = s.nack;
    assign o_rdata = s.rdata;

endmodule

`default_nettype wire

// File: design/sfts_pkg_order_note.sv
`timescale 1ns/1ns

// File: tb/sfts_sva.sv
`timescale 1ns/1ns
`default_nettype none

// Watches the shared link and the slave's flags from outside
module sfts_chk (
    input wire logic i_clock, // System clock
    input wire logic i_rst_b, // Async reset, active low
    input wire logic i_scl, // Link clock
    input wire logic i_sda, // Resolved data line
    input wire logic i_d_sda_oe, // Slave pulls data low
    input wire logic i_hs_mode, // High-speed flag
    input wire logic i_busy // Slave engaged
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_b);

    // Data rising with the clock high ends a frame
    sequence stop_s;
        i_scl && $past(i_scl) && $rose(i_sda);
    endsequence

    // Data falling with the clock high opens a frame
    sequence start_s;
        i_scl && $past(i_scl) && $fell(i_sda);
    endsequence

    chk_stop_idle: assert property (stop_s |-> ##[1:10] !i_busy)
        else $error("slave still busy after stop");
    chk_stop_hs: assert property (stop_s |-> ##[1:10] !i_hs_mode)
        else $error("high speed kept after stop");
    chk_start_wake: assert property (start_s |-> ##[1:10] i_busy)
        else $error("slave ignored start");
    chk_hs_noack: assert property ($rose(i_hs_mode) |-> !i_d_sda_oe [*8])
        else $error("master code acknowledged");
    // Slave may only start pulling while the clock is low, else it fakes a start
    chk_pull_low: assert property ($rose(i_d_sda_oe) |-> !i_scl)
        else $error("slave pulled data with clock high");
    chk_high_stable: assert property (i_scl && $past(i_scl) |-> $stable(i_d_sda_oe))
        else $error("slave data moved with clock high");
    chk_pull_holds: assert property ($rose(i_d_sda_oe) |-> i_d_sda_oe [*8])
        else $error("slave pull too short");
    chk_idle_quiet: assert property (!i_busy && !$past(i_busy) |-> !i_d_sda_oe)
        else $error("idle slave drives data");

    cover property ($rose(i_hs_mode));
    cover property ($rose(i_d_sda_oe));
    cover property (stop_s ##1 i_busy);
endmodule

`default_nettype wire

// File: tb/sfts_tb.sv
`timescale 1ns/1ns
`default_nettype none

module sfts_tb
    import sfts_pkg::*;
();
    logic i_clock, i_rst_b, i_req, i_hs, i_write_protect; // Stimulus
    logic o_busy, o_done, o_nack, o_hs_mode, d_busy, hs_seen; // Observed
    sfts_op_t i_op; // Transfer kind
    logic [2:0] i_target_select, i_device_select_pins; // Select bits
    logic [13:0] i_addr, a; // Address asked and random pick
    logic [7:0] i_wdata, o_rdata, d; // Data paths
    logic [7:0] mem [int]; // Reference array
    int cur, n_errors, compares; // Reference address and tallies

    sfts_bus_if bus ();
    sfts_master #(.QUARTER(5)) sfts_master_i (.i_clock(i_clock), .i_rst_b(i_rst_b),
        .bus(bus), .i_req(i_req), .i_op(i_op), .i_hs(i_hs),
        .i_target_select(i_target_select), .i_addr(i_addr), .i_wdata(i_wdata),
        .o_busy(o_busy), .o_done(o_done), .o_nack(o_nack), .o_rdata(o_rdata));
    sfts_device #(.FILT_CYC(2)) sfts_device_i (.i_clock(i_clock), .i_rst_b(i_rst_b),
        .bus(bus), .i_device_select_pins(i_device_select_pins),
        .i_write_protect(i_write_protect), .o_hs_mode(o_hs_mode), .o_busy(d_busy));
    sfts_chk sfts_chk_i (.i_clock(i_clock), .i_rst_b(i_rst_b),
        .i_scl(bus.scl), .i_sda(bus.sda), .i_d_sda_oe(bus.d_sda_oe),
        .i_hs_mode(o_hs_mode), .i_busy(d_busy));

    // 10 MHz system clock
    initial begin
        i_clock = 0;
        forever #50 i_clock = ~i_clock;
    end

    // Latch any high-speed entry during a transfer
    always @(posedge i_clock) begin
        if (o_hs_mode === 1'b1) hs_seen <= 1'b1;
    end

    task automatic cmp_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // One master command, then the model's verdict on it
    task automatic xfer(input sfts_op_t op, input logic hs, input logic [2:0] sel,
                        input logic [13:0] ad, input logic [7:0] wd);
        int n;
        logic ok;
        ok = (sel == i_device_select_pins);
        @(negedge i_clock);
        i_op = op;
        i_hs = hs;
        i_target_select = sel;
        i_addr = ad;
        i_wdata = wd;
        i_req = 1;
        hs_seen = 0;
        @(negedge i_clock);
        i_req = 0;
        // Request was taken at the edge just passed
        cmp_bit(o_busy, 1'b1);
        n = 0;
        // Bounded wait for the done pulse
        while (o_done !== 1'b1 && n < 20000) begin
            @(posedge i_clock);
            #1;
            n++;
        end
        if (n == 20000) begin
            n_errors++;
            finish_test();
        end
        cmp_bit(o_nack, !ok || (op == OP_WRITE && i_write_protect));
        cmp_bit(hs_seen, hs);
        if (ok && op == OP_READ) begin
            cmp_byte(o_rdata, mem[cur]);
            cur = (cur + 1) % 16384;
        end else if (ok) begin
            cur = ad;
            // Protected writes leave the address at the one sent, without the step
            if (op == OP_WRITE && !i_write_protect) begin
                mem[ad] = wd;
                cur = (ad + 1) % 16384;
            end
        end
        // Stop detection lags the pins by the filter
        repeat (6) @(posedge i_clock);
        #1;
        cmp_bit(o_hs_mode, 1'b0);
        cmp_bit(d_busy, 1'b0);
        cmp_bit(o_busy, 1'b0);
    endtask

    initial begin
        i_rst_b = 0;
        i_req = 0;
        i_op = OP_WRITE;
        i_hs = 0;
        i_target_select = 0;
        i_addr = 0;
        i_wdata = 0;
        i_write_protect = 0;
        i_device_select_pins = 3'h5;
        hs_seen = 0;
        cur = 0;
        n_errors = 0;
        compares = 0;
        void'($urandom(79));
        repeat (10) @(posedge i_clock);
        @(negedge i_clock) i_rst_b = 1;
        repeat (3) @(negedge i_clock);
        // Top of the array wraps to zero, reads run on
        xfer(OP_WRITE, 0, 3'h5, 14'h0001, 8'hc3);
        xfer(OP_WRITE, 0, 3'h5, 14'h0000, 8'h3c);
        xfer(OP_WRITE, 0, 3'h5, 14'h3fff, 8'ha5);
        xfer(OP_READ, 0, 3'h5, 14'h0000, 8'h00);
        xfer(OP_READ, 0, 3'h5, 14'h0000, 8'h00);
        xfer(OP_SETADDR, 0, 3'h5, 14'h3fff, 8'h00);
        xfer(OP_READ, 0, 3'h5, 14'h0000, 8'h00);
        // Every strap value; a foreign select must not touch the array
        for (int s = 0; s < 8; s++) begin
            @(negedge i_clock) i_device_select_pins = s[2:0];
            a = 14'($urandom);
            d = 8'($urandom);
            xfer(OP_WRITE, s[0], s[2:0], a, d);
            xfer(OP_SETADDR, 0, s[2:0], a, 8'h00);
            xfer(OP_WRITE, 0, ~s[2:0], a, ~d);
            xfer(OP_READ, s[1], s[2:0], 14'h0000, 8'h00);
        end
        // Protected write is refused and leaves the address at the one it sent
        @(negedge i_clock) i_write_protect = 1;
        xfer(OP_WRITE, 0, 3'h7, 14'h0000, 8'h99);
        @(negedge i_clock) i_write_protect = 0;
        xfer(OP_READ, 0, 3'h7, 14'h0000, 8'h00);
        finish_test();
    end

    // Hang guard, well beyond the expected run
    initial begin
        #8000000;
        n_errors++;
        finish_test();
    end
endmodule

`default_nettype wire
